// ---- rtl/chop_detect_params.svh ----
// Purpose: Constants of the chop and current-detect configuration block.
// Assumes: A 16-bit register port with a 4-bit word address.
// Notes: Offsets, reset values, field positions and window lengths.
//
// How it works
// [RQ1] With global chop on, each chop start waits 2^(code+1) clocks (code at 12:9, reset 3).
// [RQ2] Bit 7 low lets any channel declare a detection; high needs every channel.
// [RQ3] A channel qualifies after 2^code threshold hits in a window (code at 6:4, 1 to 128).
// [RQ4] Bits 3:1 pick a window of 128 to 3584 conversions; bit 0 (reset 0) runs detection.
// [RQ5] The threshold high word is a 16-bit read/write register at 7h resetting to 0000h.
// [RQ6] Bits 15:8 of the register at 8h hold the threshold low byte, under the high word.
// [RQ7] The chop and detect configuration register sits at 6h and resets to 0600h.
// [RQ8] Each window counts results above the threshold, flags a detection, then restarts.
`ifndef CHOP_DETECT_PARAMS_SVH
`define CHOP_DETECT_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define CFG_ADDR 4'h6
`define THR_HI_ADDR 4'h7
`define THR_LO_ADDR 4'h8
`define IRQ_STAT_ADDR 4'hA
`define IRQ_MASK_ADDR 4'hB
`define STATE_ADDR 4'hC
`define CFG_RESET 16'h0600
`define THR_RESET 16'h0000
`define LO_BYTE_MSB 15
`define LO_BYTE_LSB 8
`define IRQ_DETECT 0
`define IRQ_SETTLED 1

// ****************************************
// Window lengths in conversions
// ****************************************
`define WIN_LEN0 12'd128
`define WIN_LEN1 12'd256
`define WIN_LEN2 12'd512
`define WIN_LEN3 12'd768
`define WIN_LEN4 12'd1280
`define WIN_LEN5 12'd1792
`define WIN_LEN6 12'd2560
`define WIN_LEN7 12'd3584

`endif

// ---- rtl/chop_detect_pkg.sv ----
// Purpose: Types shared by the chop and current-detect block.
// Assumes: Nothing beyond the parameter header.
// Notes: The configuration struct mirrors the register bit by bit.
`default_nettype none
package chop_detect_pkg;

   // Register port request, all on the block clock.
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   // Configuration register, most significant field first.
   typedef struct packed {
      logic [2:0] reserved;
      logic [3:0] chop_settle_delay_sel;
      logic global_chop_on;
      logic detect_all_channels;
      logic [2:0] detect_hit_count_sel;
      logic [2:0] detect_window_length_sel;
      logic detect_mode_on;
   } cfg_type;

   typedef enum logic [1:0] {CHOP_IDLE, CHOP_SETTLE, CHOP_MEASURE} chop_state_type;

endpackage

`default_nettype wire

// ---- rtl/chop_and_current_detect_config.sv ----
// Purpose: Chop settling delay and current-detect window logic with registers.
// Assumes: clk is the modulator clock; conversion results arrive on the same clock.
// Notes: Register reads answer one cycle after the strobe; ce low freezes everything.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "chop_detect_params.svh"
`default_nettype none

module chop_and_current_detect_config #(
   parameter int NCH = 3
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire chop_detect_pkg::bus_req_type busReq,
   output logic [15:0] rdata,
   // Conversion stream
   input wire logic chopStart,
   input wire logic convValid,
   input wire logic [NCH-1:0][23:0] convData,
   // Status
   output logic chopSettling,
   output logic detectPulse,
   output logic detected,
   output logic irq
);
   import chop_detect_pkg::*;

   // ****************************************
   // Decoders
   // ****************************************

   // Settling delay of 2^(code+1) clocks, 17 bits to reach 65536.
   function automatic logic [16:0] chopDelay(input logic [3:0] code);
      chopDelay = 17'h00002 << code;
   endfunction

   // Required hits, 1 to 128.
   function automatic logic [7:0] hitsNeeded(input logic [2:0] code);
      hitsNeeded = 8'h01 << code;
   endfunction

   function automatic logic [11:0] windowLen(input logic [2:0] code);
      case (code)
         3'h0: windowLen = `WIN_LEN0;
         3'h1: windowLen = `WIN_LEN1;
         3'h2: windowLen = `WIN_LEN2;
         3'h3: windowLen = `WIN_LEN3;
         3'h4: windowLen = `WIN_LEN4;
         3'h5: windowLen = `WIN_LEN5;
         3'h6: windowLen = `WIN_LEN6;
         default: windowLen = `WIN_LEN7;
      endcase
   endfunction

   // Two's complement magnitude; the most negative code gives 800000h, still in range.
   function automatic logic [23:0] magnitude(input logic [23:0] x);
      magnitude = x[23] ? 24'(~x + 24'h000001) : x;
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] cfgReg;
   logic [15:0] thrHi;
   logic [7:0] thrLo;
   logic [1:0] irqStat;
   logic [1:0] irqMask;
   cfg_type cfg;
   logic wrCfg, wrHi, wrLo, wrStat, wrMask;
   logic [23:0] threshold;

   assign cfg = cfg_type'(cfgReg);
   assign wrCfg = ce && busReq.wr && busReq.addr == `CFG_ADDR;
   assign wrHi = ce && busReq.wr && busReq.addr == `THR_HI_ADDR;
   assign wrLo = ce && busReq.wr && busReq.addr == `THR_LO_ADDR;
   assign wrStat = ce && busReq.wr && busReq.addr == `IRQ_STAT_ADDR;
   assign wrMask = ce && busReq.wr && busReq.addr == `IRQ_MASK_ADDR;

   // [RQ6] full threshold
   assign threshold = {thrHi, thrLo};

   // Configuration register, reserved bits kept as written.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // [RQ7] reset to 0600h
         cfgReg <= `CFG_RESET;
      end else if (wrCfg) begin
         cfgReg <= busReq.wdata;
      end
   end

   // Threshold high word and low byte.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         thrHi <= `THR_RESET;
         thrLo <= 8'h00;
      end else begin
         // [RQ5] high word write
         if (wrHi) begin
            thrHi <= busReq.wdata;
         end
         // [RQ6] low byte write
         if (wrLo) begin
            thrLo <= busReq.wdata[`LO_BYTE_MSB:`LO_BYTE_LSB];
         end
      end
   end

   // ****************************************
   // Chop settling
   // ****************************************
   chop_state_type chopState;
   logic [16:0] settleCnt;
   logic settleDone;

   assign settleDone = chopState == CHOP_SETTLE && settleCnt == 17'(chopDelay(
      cfg.chop_settle_delay_sel) - 17'h00001);
   assign chopSettling = chopState == CHOP_SETTLE;

   // A new chop start restarts the wait, so a late phase swap is never measured early.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chopState <= CHOP_IDLE;
         settleCnt <= 17'h00000;
      end else if (ce) begin
         case (chopState)
            CHOP_IDLE: begin
               settleCnt <= 17'h00000;
               if (cfg.global_chop_on && chopStart) begin
                  chopState <= CHOP_SETTLE;
               end
            end
            CHOP_SETTLE: begin
               // [RQ1] count the delay
               if (!cfg.global_chop_on) begin
                  chopState <= CHOP_IDLE;
               end else if (chopStart) begin
                  settleCnt <= 17'h00000;
               end else if (settleDone) begin
                  chopState <= CHOP_MEASURE;
               end else begin
                  settleCnt <= settleCnt + 17'h00001;
               end
            end
            CHOP_MEASURE: begin
               settleCnt <= 17'h00000;
               if (!cfg.global_chop_on) begin
                  chopState <= CHOP_IDLE;
               end else if (chopStart) begin
                  chopState <= CHOP_SETTLE;
               end
            end
            default: chopState <= CHOP_IDLE;
         endcase
      end
   end

   // ****************************************
   // Current detection
   // ****************************************
   logic [11:0] windowCnt;
   logic [NCH-1:0][7:0] hitCnt;
   logic [NCH-1:0][7:0] next_hitCnt;
   logic [NCH-1:0] hitMet;
   logic countable, windowEnd, qualify;

   assign countable = cfg.detect_mode_on && convValid && !chopSettling;
   assign windowEnd = countable && windowCnt == 12'(windowLen(
      cfg.detect_window_length_sel) - 12'h001);

   // Hits including the present conversion, saturating so a long window cannot wrap.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         next_hitCnt[c] = hitCnt[c];
         // [RQ8] threshold exceeded
         if (magnitude(convData[c]) > threshold && hitCnt[c] != 8'hFF) begin
            next_hitCnt[c] = hitCnt[c] + 8'h01;
         end
         // [RQ3] hit number
         hitMet[c] = next_hitCnt[c] >= hitsNeeded(cfg.detect_hit_count_sel);
      end
   end

   // [RQ2] any or all channels
   assign qualify = cfg.detect_all_channels ? &hitMet : |hitMet;

   // Window position; detection off holds it cleared.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         windowCnt <= 12'h000;
      end else if (ce) begin
         // [RQ4] window length and enable
         if (!cfg.detect_mode_on || windowEnd) begin
            windowCnt <= 12'h000;
         end else if (countable) begin
            windowCnt <= windowCnt + 12'h001;
         end
      end
   end

   // Hit counters per channel.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hitCnt <= '0;
      end else if (ce) begin
         // [RQ8] restart each window
         if (!cfg.detect_mode_on || windowEnd) begin
            hitCnt <= '0;
         end else if (countable) begin
            hitCnt <= next_hitCnt;
         end
      end
   end

   // Verdict at each window end; the level holds until the next window ends or detection is switched off.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         detectPulse <= 1'b0;
         detected <= 1'b0;
      end else if (ce) begin
         // [RQ8] declare detection
         detectPulse <= windowEnd && qualify;
         if (!cfg.detect_mode_on) begin
            detected <= 1'b0;
         end else if (windowEnd) begin
            detected <= qualify;
         end
      end
   end

   // ****************************************
   // Interrupts and read port
   // ****************************************
   // Sticky events; a set in the clearing cycle wins over the write of one.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqStat <= 2'h0;
         irqMask <= 2'h0;
      end else if (ce) begin
         irqStat[`IRQ_DETECT] <= detectPulse ||
            (irqStat[`IRQ_DETECT] && !(wrStat && busReq.wdata[`IRQ_DETECT]));
         irqStat[`IRQ_SETTLED] <= settleDone ||
            (irqStat[`IRQ_SETTLED] && !(wrStat && busReq.wdata[`IRQ_SETTLED]));
         if (wrMask) begin
            irqMask <= busReq.wdata[1:0];
         end
      end
   end

   assign irq = |(irqStat & irqMask);

   // Read data for exactly the cycle after the strobe; unmapped words read zero.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         rdata <= 16'h0000;
         if (busReq.rd) begin
            case (busReq.addr)
               `CFG_ADDR: rdata <= cfgReg;
               `THR_HI_ADDR: rdata <= thrHi;
               `THR_LO_ADDR: rdata <= {thrLo, 8'h00};
               `IRQ_STAT_ADDR: rdata <= {14'h0000, irqStat};
               `IRQ_MASK_ADDR: rdata <= {14'h0000, irqMask};
               `STATE_ADDR: rdata <= {windowCnt, 1'b0, detected, chopSettling,
                  chopState == CHOP_MEASURE};
               default: rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // All checks share the block clock and sleep while reset is held.
   default clocking checkClk @(posedge clk);
   endclocking
   default disable iff (!rstn);

   property p_cfg_reset;
      $rose(rstn) |-> cfgReg == `CFG_RESET;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) // [RQ7]
      else $error("Configuration register did not reset to 0600h.");
   property p_settle_hold;
      chopSettling && ce && cfg.global_chop_on && !settleDone |=> chopSettling;
   endproperty
   a_settle_hold: assert property (p_settle_hold) // [RQ1]
      else $error("Chop settling ended before its delay.");
   property p_settle_short;
      ce && !chopSettling && chopStart && cfg.global_chop_on && !wrCfg &&
      cfg.chop_settle_delay_sel == 4'h0 ##1 (ce && !chopStart && !wrCfg) [*2]
      |=> !chopSettling && chopState == CHOP_MEASURE;
   endproperty
   a_settle_short: assert property (p_settle_short) // [RQ1]
      else $error("Two-clock chop delay not honoured.");
   property p_all_channels;
      ce && windowEnd && cfg.detect_all_channels && !(&hitMet) |=> !detectPulse;
   endproperty
   a_all_channels: assert property (p_all_channels) // [RQ2]
      else $error("Detection declared without every channel.");
   property p_any_channel;
      ce && windowEnd && !cfg.detect_all_channels && |hitMet |=> detectPulse && detected;
   endproperty
   a_any_channel: assert property (p_any_channel) // [RQ2]
      else $error("Single qualifying channel did not detect.");
   property p_hit_count;
      detectPulse && $past(ce) |-> $past(|hitMet);
   endproperty
   a_hit_count: assert property (p_hit_count) // [RQ3]
      else $error("Detection declared below the hit number.");
   property p_mode_off;
      ce && !cfg.detect_mode_on && !wrCfg |=> windowCnt == 12'h000 && !detected && !detectPulse;
   endproperty
   a_mode_off: assert property (p_mode_off) // [RQ4]
      else $error("Detection active while disabled.");
   property p_window_end;
      detectPulse && $past(ce) |->
         $past(windowCnt) == 12'($past(windowLen(cfg.detect_window_length_sel)) - 12'h001);
   endproperty
   a_window_end: assert property (p_window_end) // [RQ4]
      else $error("Detection outside the window end.");
   property p_thr_hi;
      wrHi ##1 ce && busReq.rd && busReq.addr == `THR_HI_ADDR && !busReq.wr
      |=> rdata == $past(busReq.wdata, 2);
   endproperty
   a_thr_hi: assert property (p_thr_hi) // [RQ5]
      else $error("Threshold high word did not read back.");
   property p_thr_lo;
      ce && busReq.rd && busReq.addr == `THR_LO_ADDR |=> rdata == {threshold[7:0], 8'h00};
   endproperty
   a_thr_lo: assert property (p_thr_lo) // [RQ6]
      else $error("Threshold low byte read wrong.");
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the chop and current-detect block.
// Assumes: Reads answer one cycle after the strobe; the design holds its own assertions.
// Notes: Short chop codes and short windows keep the run brief.
`timescale 1ns/1ps
`include "chop_detect_params.svh"
`default_nettype none

module testbench;
   import chop_detect_pkg::*;

   // ****************************************
   // Signals and instance
   // ****************************************
   localparam int NCH = 3;
   localparam int WIN_LEN [8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   bus_req_type busReq = '0;
   logic [15:0] rdata;
   logic chopStart = 1'b0;
   logic convValid = 1'b0;
   logic [NCH-1:0][23:0] convData = '0;
   logic chopSettling, detectPulse, detected, irq;
   int num_errors = 0;
   int tests_run = 0;

   chop_and_current_detect_config #(.NCH(NCH)) u_chop_and_current_detect_config (
      .clk(clk), .rstn(rstn), .ce(ce), .busReq(busReq), .rdata(rdata),
      .chopStart(chopStart), .convValid(convValid), .convData(convData),
      .chopSettling(chopSettling), .detectPulse(detectPulse), .detected(detected), .irq(irq));

   // The clock toggles every half period of 5 ns.
   always #5 clk = ~clk;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A spare edge after each strobe keeps a strobe from being driven twice in one step.
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 check(rdata, exp);
      @(posedge clk);
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_reset_values();
      check({chopSettling, detectPulse, detected, irq}, 16'h0000);
      reg_check(`CFG_ADDR, 16'h0600);
      reg_check(`THR_HI_ADDR, 16'h0000);
      reg_check(`THR_LO_ADDR, 16'h0000);
      reg_check(`IRQ_STAT_ADDR, 16'h0000);
      reg_check(`IRQ_MASK_ADDR, 16'h0000);
      reg_check(`STATE_ADDR, 16'h0000);
      $display("Reset values done");
   endtask

   task automatic test_registers();
      reg_write(`THR_HI_ADDR, 16'hA5C3);
      reg_check(`THR_HI_ADDR, 16'hA5C3);
      reg_write(`THR_HI_ADDR, 16'hFFFF);
      reg_check(`THR_HI_ADDR, 16'hFFFF);
      reg_write(`THR_LO_ADDR, 16'hFFFF);
      reg_check(`THR_LO_ADDR, 16'hFF00);
      reg_write(`CFG_ADDR, 16'hFFFF);
      reg_check(`CFG_ADDR, 16'hFFFF);
      reg_write(4'h3, 16'h1234);
      reg_check(4'h3, 16'h0000);
      // A write while the clock enable is low must be dropped.
      ce <= 1'b0;
      reg_write(`THR_HI_ADDR, 16'h1111);
      ce <= 1'b1;
      reg_check(`THR_HI_ADDR, 16'hFFFF);
      // Write then read with no idle cycle, one assignment of the bus per edge.
      busReq <= '{addr: `THR_HI_ADDR, wdata: 16'h5A3C, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq <= '{addr: `THR_HI_ADDR, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq <= '0;
      #1 check(rdata, 16'h5A3C);
      @(posedge clk);
      reg_write(`CFG_ADDR, 16'h0000);
      $display("Register access done");
   endtask

   task automatic test_chop();
      int n;
      reg_write(`IRQ_MASK_ADDR, 16'h0002);
      reg_check(`IRQ_MASK_ADDR, 16'h0002);
      // With global chop off a start pulse must not begin settling.
      chopStart <= 1'b1;
      @(posedge clk);
      chopStart <= 1'b0;
      #1 check(chopSettling, 1'b0);
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         reg_write(`CFG_ADDR, {3'b000, 4'(k), 1'b1, 8'h00});
         chopStart <= 1'b1;
         @(posedge clk);
         chopStart <= 1'b0;
         n = 0;
         #1;
         while (chopSettling === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
            #1;
         end
         check(16'(n), 16'(2 << k));
         check(irq, 1'b1);
         @(posedge clk);
         reg_check(`IRQ_STAT_ADDR, 16'h0002);
         reg_write(`IRQ_STAT_ADDR, 16'h0002);
         #1 check(irq, 1'b0);
         @(posedge clk);
      end
      // Settling is over with chop still on, so the state word shows measuring only.
      reg_check(`STATE_ADDR, 16'h0001);
      reg_write(`CFG_ADDR, 16'h0000);
      $display("Chop settling done");
   endtask

   // Hits alternate sign; misses sit exactly on the threshold, which must not count.
   task automatic detect_case(input logic allCh, input logic [2:0] sel, input logic [2:0] win,
                              input int h0, input int h1, input int h2, input logic exp);
      int hits [NCH];
      hits = '{h0, h1, h2};
      reg_write(`CFG_ADDR, 16'h0000);
      reg_write(`CFG_ADDR, {8'h00, allCh, sel, win, 1'b1});
      for (int i = 0; i < WIN_LEN[win]; i++) begin
         convValid <= 1'b1;
         for (int c = 0; c < NCH; c++) begin
            convData[c] <= (i < hits[c]) ? ((i % 2) ? 24'hFFFEFF : 24'h000101)
                                         : ((i % 2) ? 24'hFFFF00 : 24'h000100);
         end
         @(posedge clk);
      end
      convValid <= 1'b0;
      #1 check(detectPulse, exp);
      check(detected, exp);
      @(posedge clk);
      #1 check(detectPulse, 1'b0);
      check(irq, exp);
      @(posedge clk);
      reg_write(`IRQ_STAT_ADDR, 16'h0001);
   endtask

   task automatic test_detect();
      reg_write(`THR_HI_ADDR, 16'h0001);
      reg_write(`THR_LO_ADDR, 16'h0000);
      reg_write(`IRQ_MASK_ADDR, 16'h0001);
      detect_case(1'b0, 3'd1, 3'd0, 2, 0, 0, 1'b1);
      detect_case(1'b0, 3'd1, 3'd0, 1, 0, 0, 1'b0);
      detect_case(1'b1, 3'd0, 3'd0, 1, 1, 0, 1'b0);
      detect_case(1'b1, 3'd0, 3'd1, 1, 1, 1, 1'b1);
      detect_case(1'b0, 3'd7, 3'd3, 127, 0, 0, 1'b0);
      // The last window detects, so switching the mode off has a verdict to clear.
      detect_case(1'b0, 3'd7, 3'd0, 128, 0, 0, 1'b1);
      reg_write(`CFG_ADDR, 16'h0000);
      #1 check(detected, 1'b0);
      @(posedge clk);
      $display("Current detection done");
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      test_reset_values();
      test_registers();
      test_chop();
      test_detect();
      wrap_up();
   end

   // The whole run needs well under 3000 cycles, so this limit only trips on a hang.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("Watchdog expired at %0t", $time);
      wrap_up();
   end

endmodule
`default_nettype wire
